// ==== src/angle_cond_defs.svh ====
// Offsets, field positions, reset values and times in ns of the
// angle output conditioning path. Assumes a 125 MHz system clock.
`ifndef ANGLE_COND_DEFS_SVH
`define ANGLE_COND_DEFS_SVH
`define CLK_PERIOD_NS 8
// Register indices on the programming port.
`define IDX_HYST   6'h00
`define IDX_REF    6'h01
`define IDX_PRE    6'h02
`define IDX_SCALE  6'h03
`define IDX_SHIFT  6'h04
`define IDX_CLO    6'h05
`define IDX_CHI    6'h06
`define IDX_MFLOOR 6'h07
`define IDX_MCEIL  6'h08
`define IDX_LP     6'h09
`define IDX_CUST   6'h0A
`define IDX_WRAP   6'h0B
`define IDX_STATUS 6'h0C
`define IDX_OUT    6'h0D
`define IDX_SP0    6'h10
`define IDX_SPN    6'h30
// Customer configuration word fields.
`define CW_LOCK    0
`define CW_NOFORCE 1
`define CW_LATCH   2
`define CW_COMM    4
`define CW_BANDLO  7
`define CW_SHORT   9:8
`define CW_PRATE   11:10
`define CW_FORMAT  12
`define CW_SPEED   13
`define CW_MASK    16'h7FFF
// Reset values.
`define RST_SCALE  16'h0200
`define RST_CHI    16'h8000
`define RST_MFLOOR 16'h8000
`define RST_MCEIL  16'h7FFF
// Arithmetic scaling: unity gain 512, shift LSB is two output codes.
`define SCALE_SHIFT 9
`define SEG_STEP    1024
`define ERR_BAND_HIGH 16'hFFFF
`define ERR_BAND_LOW  16'h0000
// Times in ns.
`define BIT_SLOW_NS 1000000
`define BIT_FAST_NS 250000
`define PWM_1K_NS   1000000
`define PWM_500_NS  2000000
`define PWM_200_NS  5000000
`define PWM_2K_NS   500000
`endif

// ==== src/angle_cond_pkg.sv ====
// Types of the angle output conditioning path.
// Assumes the defs header supplies all numeric constants.
package angle_cond_pkg;
   typedef enum logic [1:0] {
      DRV_NORMAL = 2'h0,
      DRV_HIGH   = 2'h1,
      DRV_TRI    = 2'h3,
      DRV_LOW    = 2'h2
   } drive_e;

   // One measurement sample from the front end.
   typedef struct packed {
      logic [15:0] ch1;
      logic [15:0] ch2;
      logic [15:0] angle;
      logic [15:0] magnitude;
      logic        fault;
   } sample_s;

   typedef struct packed {
      logic [15:0]        hyst, ref_ang, pre, scale, shift;
      logic [15:0]        clo, chi, mfloor, mceil, lp, cust, wrap;
      logic [32:0][15:0]  sp;
      logic [15:0]        h1, h2, ang, lin;
      logic signed [31:0] sum, filt;
      logic [3:0]         vld, mlo, mhi, dflt;
      logic [5:0]         status;
      logic [15:0]        out;
      logic               ovld;
      drive_e             drv;
      logic [15:0]        rdata;
      logic [19:0]        bit_time, pwm_period;
      logic               pwm_11b, sent_sel, comm_en, locked;
   } state_s;
endpackage

// ==== src/angle_output_conditioning.sv ====
// Angle output conditioning: hysteresis, reference, pre-shift, segment
// wrap, 33-point linearisation, gain, shift, low-pass, clamp, magnitude
// check, fault forcing and customer word decode.
// Assumes samples and register accesses are synchronous to CLK.
//
// Contract
// - Hysteresis of 1 to 32768 codes on both channels before angle.
// - Hysteresis stored negative; zero disables it completely.
// - Signed reference angle sets output zero and setpoint origin.
// - Signed pre-shift added to move range away from overflow.
// - Output multiplied by signed scale, -64 to 64, unity full span.
// - Signed output shift of -200% to 200%; 32768 means -200%.
// - Output limited between lower and upper clamp levels.
// - Magnitude outside floor or ceiling forces upper clamp output.
// - First-order low-pass, corner chosen by code, code zero bypass.
// - Optional fold into four 90 or three 120 degree segments.
// - 32 equal segments, linear interpolation between setpoints.
// - Word bit 13 picks bit time, 1 ms or 0.25 ms.
// - Word bit 12 picks pulse-width or SENT output format.
// - Word bits 11:10 pick pulse rate 1k, 500, 200 or 2k Hz.
// - Word bits 9:8 pick output short handling and rail.
// - Word bit 7 picks error band when locked; unlocked uses high.
// - Word bit 4 enables communication over the output pin.
// - Word bit 2 latches diagnosis bits until reset.
// - Word bit 1 clear lets diagnosis errors force the error band.
// - Writing 1 to word bit 0 locks memory against changes.
`timescale 1ns/10ps
`include "angle_cond_defs.svh"

module angle_output_conditioning #(
   parameter int BIT_SLOW_CYC = `BIT_SLOW_NS / `CLK_PERIOD_NS,
   parameter int BIT_FAST_CYC = `BIT_FAST_NS / `CLK_PERIOD_NS,
   parameter int PWM_1K_CYC   = `PWM_1K_NS / `CLK_PERIOD_NS,
   parameter int PWM_500_CYC  = `PWM_500_NS / `CLK_PERIOD_NS,
   parameter int PWM_200_CYC  = `PWM_200_NS / `CLK_PERIOD_NS,
   parameter int PWM_2K_CYC   = `PWM_2K_NS / `CLK_PERIOD_NS
) (
   input  wire logic                   CLK,
   input  wire logic                   RST,
   input  wire logic                   PROG_WE,
   input  wire logic [5:0]             PROG_SEL,
   input  wire logic [15:0]            PROG_WDATA,
   output logic [15:0]                 PROG_RDATA,
   input  wire logic                   SAMPLE_VALID,
   input  wire angle_cond_pkg::sample_s SAMPLE,
   input  wire logic                   SHORT_HIGH_SIDE,
   input  wire logic                   SHORT_LOW_SIDE,
   output logic [15:0]                 HELD_FIRST,
   output logic [15:0]                 HELD_SECOND,
   output logic [15:0]                 OUT_VALUE,
   output logic                        OUT_VALID,
   output angle_cond_pkg::drive_e      OUT_DRIVE,
   output logic [5:0]                  DIAG_STATUS,
   output logic [19:0]                 BIT_TIME,
   output logic [19:0]                 PULSE_PERIOD,
   output logic                        PULSE_11BIT,
   output logic                        DIGITAL_OUTPUT_FORMAT,
   output logic                        PIN_COMMUNICATION_MODE,
   output logic                        MEMORY_LOCKED
);

   angle_cond_pkg::state_s s;
   angle_cond_pkg::state_s next_s;

   // Follows the input only once it moves beyond the threshold.
   function automatic logic [15:0] track(input logic [15:0] x,
                                         input logic [15:0] held,
                                         input logic [15:0] hyst);
      logic signed [16:0] d;
      logic [16:0]        mag;
      logic [16:0]        th;
      d   = signed'({x[15], x}) - signed'({held[15], held});
      mag = d[16] ? 17'(-d) : 17'(d);
      th  = 17'(-signed'({hyst[15], hyst}));
      if (hyst == 16'h0000 || mag > th)
         track = x;
      else
         track = held;
   endfunction

   // Interpolates between the two setpoints around the position.
   function automatic logic [15:0] lin_f(input logic [15:0] a,
                                         input logic [32:0][15:0] sp);
      logic [14:0]        pos;
      logic [5:0]         i;
      logic signed [16:0] d;
      logic signed [28:0] p;
      pos   = a[15:1];
      i     = {1'b0, pos[14:10]};
      d     = signed'({1'b0, sp[i + 6'h01]}) - signed'({1'b0, sp[i]});
      p     = 29'(d * signed'({1'b0, pos[9:0]}));
      lin_f = 16'(signed'({1'b0, sp[i]}) + 17'(p >>> 10));
   endfunction

   // Neutral settings and a straight linearisation curve of half slope.
   function automatic angle_cond_pkg::state_s rst_s();
      angle_cond_pkg::state_s r;
      r        = '0;
      r.scale  = `RST_SCALE;
      r.chi    = `RST_CHI;
      r.mfloor = `RST_MFLOOR;
      r.mceil  = `RST_MCEIL;
      for (int i = 0; i < 33; i++)
         r.sp[i] = 16'(i * `SEG_STEP);
      r.bit_time   = 20'(BIT_SLOW_CYC);
      r.pwm_period = 20'(PWM_1K_CYC);
      r.drv        = angle_cond_pkg::DRV_NORMAL;
      return r;
   endfunction

   logic               wr;
   logic [15:0]        a;
   logic signed [31:0] m;
   logic signed [31:0] x;
   logic [15:0]        v;
   logic               hit_lo;
   logic               hit_hi;
   logic               band_low;
   logic               forced;
   logic               any_short;
   logic [5:0]         new_stat;

   // Register file, five-stage sample path and configuration decode.
   always_comb
   begin
      next_s    = s;
      next_s.ovld = 1'b0;
      a         = 16'h0000;
      m         = '0;
      x         = '0;
      v         = 16'h0000;
      hit_lo    = 1'b0;
      hit_hi    = 1'b0;
      band_low  = s.cust[`CW_LOCK] & s.cust[`CW_BANDLO];
      forced    = 1'b0;
      any_short = SHORT_HIGH_SIDE | SHORT_LOW_SIDE;
      new_stat  = 6'h00;
      wr = PROG_WE && !s.cust[`CW_LOCK];
      if (wr)
      begin
         unique case (PROG_SEL)
            `IDX_HYST:   next_s.hyst    = PROG_WDATA;
            `IDX_REF:    next_s.ref_ang = PROG_WDATA;
            `IDX_PRE:    next_s.pre     = PROG_WDATA;
            `IDX_SCALE:  next_s.scale   = PROG_WDATA;
            `IDX_SHIFT:  next_s.shift   = PROG_WDATA;
            `IDX_CLO:    next_s.clo     = PROG_WDATA;
            `IDX_CHI:    next_s.chi     = PROG_WDATA;
            `IDX_MFLOOR: next_s.mfloor  = PROG_WDATA;
            `IDX_MCEIL:  next_s.mceil   = PROG_WDATA;
            `IDX_LP:     next_s.lp      = PROG_WDATA;
            `IDX_CUST:   next_s.cust    = PROG_WDATA & `CW_MASK;
            `IDX_WRAP:   next_s.wrap    = PROG_WDATA;
            default:
            begin
               if (PROG_SEL >= `IDX_SP0 && PROG_SEL <= `IDX_SPN)
                  next_s.sp[PROG_SEL - `IDX_SP0] = PROG_WDATA;
            end
         endcase
      end
      // Read data is registered; unmapped indices read zero.
      unique case (PROG_SEL)
         `IDX_HYST:   next_s.rdata = s.hyst;
         `IDX_REF:    next_s.rdata = s.ref_ang;
         `IDX_PRE:    next_s.rdata = s.pre;
         `IDX_SCALE:  next_s.rdata = s.scale;
         `IDX_SHIFT:  next_s.rdata = s.shift;
         `IDX_CLO:    next_s.rdata = s.clo;
         `IDX_CHI:    next_s.rdata = s.chi;
         `IDX_MFLOOR: next_s.rdata = s.mfloor;
         `IDX_MCEIL:  next_s.rdata = s.mceil;
         `IDX_LP:     next_s.rdata = s.lp;
         `IDX_CUST:   next_s.rdata = s.cust;
         `IDX_WRAP:   next_s.rdata = s.wrap;
         `IDX_STATUS: next_s.rdata = {10'h000, s.status};
         `IDX_OUT:    next_s.rdata = s.out;
         default:
         begin
            if (PROG_SEL >= `IDX_SP0 && PROG_SEL <= `IDX_SPN)
               next_s.rdata = s.sp[PROG_SEL - `IDX_SP0];
            else
               next_s.rdata = 16'h0000;
         end
      endcase

      // Stage flags ride along with the sample.
      next_s.vld  = {s.vld[2:0], SAMPLE_VALID};
      next_s.mlo  = {s.mlo[2:0], 1'b0};
      next_s.mhi  = {s.mhi[2:0], 1'b0};
      next_s.dflt = {s.dflt[2:0], 1'b0};
      // Stage 1: channel hysteresis, reference, pre-shift and fold.
      if (SAMPLE_VALID)
      begin
         next_s.h1 = track(SAMPLE.ch1, s.h1, s.hyst);
         next_s.h2 = track(SAMPLE.ch2, s.h2, s.hyst);
         a = SAMPLE.angle - s.ref_ang;
         a = a + s.pre;
         unique case (s.wrap[1:0])
            2'h1:    next_s.ang = {a[13:0], 2'h0};
            2'h2:    next_s.ang = a + {a[14:0], 1'b0};
            default: next_s.ang = a;
         endcase
         next_s.mlo[0] = $signed(SAMPLE.magnitude) < $signed(s.mfloor);
         next_s.mhi[0] = $signed(SAMPLE.magnitude) > $signed(s.mceil);
         next_s.dflt[0] = SAMPLE.fault;
      end
      // Stage 2: piecewise linear curve.
      if (s.vld[0])
      begin
         next_s.lin = lin_f(s.ang, s.sp);
      end
      // Stage 3: gain and shift; a wide sum keeps overflow visible.
      if (s.vld[1])
      begin
         m = 32'(signed'({1'b0, s.lin})) * 32'(signed'(s.scale));
         next_s.sum = (m >>> `SCALE_SHIFT)
                    + (32'(signed'(s.shift)) <<< 1);
      end
      // Stage 4: low-pass; a code of zero passes the sum through.
      if (s.vld[2])
      begin
         next_s.filt = s.filt + ((s.sum - s.filt) >>> s.lp[3:0]);
      end
      // Stage 5: clamp, magnitude and fault forcing.
      if (s.vld[3])
      begin
         x      = s.filt;
         hit_lo = x < $signed({16'h0000, s.clo});
         hit_hi = x > $signed({16'h0000, s.chi});
         if (hit_lo)
            v = s.clo;
         else if (hit_hi)
            v = s.chi;
         else
            v = x[15:0];
         if (s.mlo[3] || s.mhi[3])
            v = s.chi;
         forced = s.dflt[3] && !s.cust[`CW_NOFORCE];
         if (forced)
            v = band_low ? `ERR_BAND_LOW : `ERR_BAND_HIGH;
         next_s.out  = v;
         next_s.ovld = 1'b1;
         new_stat = {any_short, s.dflt[3], hit_hi, hit_lo,
                     s.mhi[3], s.mlo[3]};
         if (s.cust[`CW_LATCH])
            next_s.status = s.status | new_stat;
         else
            next_s.status = new_stat;
      end

      unique case (s.cust[`CW_SHORT])
         2'h0: next_s.drv = angle_cond_pkg::DRV_NORMAL;
         2'h1: next_s.drv = !any_short ? angle_cond_pkg::DRV_NORMAL :
                            band_low ? angle_cond_pkg::DRV_LOW :
                                       angle_cond_pkg::DRV_HIGH;
         2'h2: next_s.drv = !any_short ? angle_cond_pkg::DRV_NORMAL :
                            band_low ? angle_cond_pkg::DRV_HIGH :
                                       angle_cond_pkg::DRV_LOW;
         2'h3: next_s.drv = SHORT_LOW_SIDE ? angle_cond_pkg::DRV_TRI :
                                             angle_cond_pkg::DRV_NORMAL;
      endcase
      next_s.bit_time = s.cust[`CW_SPEED] ? 20'(BIT_FAST_CYC)
                                          : 20'(BIT_SLOW_CYC);
      unique case (s.cust[`CW_PRATE])
         2'h0: next_s.pwm_period = 20'(PWM_1K_CYC);
         2'h1: next_s.pwm_period = 20'(PWM_500_CYC);
         2'h2: next_s.pwm_period = 20'(PWM_200_CYC);
         2'h3: next_s.pwm_period = 20'(PWM_2K_CYC);
      endcase
      next_s.pwm_11b = s.cust[`CW_PRATE] == 2'h3;
      next_s.sent_sel = s.cust[`CW_FORMAT];
      next_s.comm_en = s.cust[`CW_COMM];
      next_s.locked  = s.cust[`CW_LOCK];
      if (RST)
         next_s = rst_s();
   end

   // Single state register; reset is folded into the next value.
   always_ff @(posedge CLK)
   begin
      s <= next_s;
   end

   // All outputs come straight from state flip-flops.
   assign PROG_RDATA             = s.rdata;
   assign HELD_FIRST             = s.h1;
   assign HELD_SECOND            = s.h2;
   assign OUT_VALUE              = s.out;
   assign OUT_VALID              = s.ovld;
   assign OUT_DRIVE              = s.drv;
   assign DIAG_STATUS            = s.status;
   assign BIT_TIME               = s.bit_time;
   assign PULSE_PERIOD           = s.pwm_period;
   assign PULSE_11BIT            = s.pwm_11b;
   assign DIGITAL_OUTPUT_FORMAT  = s.sent_sel;
   assign PIN_COMMUNICATION_MODE = s.comm_en;
   assign MEMORY_LOCKED          = s.locked;

   // Checks on the sample path and configuration.
   a_hyst_off: assert property (@(posedge CLK) disable iff (RST)
      (SAMPLE_VALID && s.hyst == 16'h0000) |=> s.h1 == $past(SAMPLE.ch1))
      else $error("zero hysteresis did not pass channel through");
   a_hyst_hold: assert property (@(posedge CLK) disable iff (RST)
      (SAMPLE_VALID && s.hyst[15] && s.hyst != 16'hFFFF
       && SAMPLE.ch1[15] == s.h1[15] && 16'(SAMPLE.ch1 - s.h1) == 16'h0002)
      |=> $stable(s.h1))
      else $error("held channel moved inside hysteresis");
   a_ref_shift: assert property (@(posedge CLK) disable iff (RST)
      (SAMPLE_VALID && s.wrap[1:0] == 2'h0) |=>
      s.ang == 16'($past(SAMPLE.angle) - $past(s.ref_ang) + $past(s.pre)))
      else $error("angle not referenced and pre-shifted");
   a_clamp_band: assert property (@(posedge CLK) disable iff (RST)
      (s.vld[3] && !s.mlo[3] && !s.mhi[3] && !s.dflt[3] && s.clo <= s.chi)
      |=> OUT_VALID && OUT_VALUE >= $past(s.clo)
          && OUT_VALUE <= $past(s.chi))
      else $error("output left the clamp band");
   a_mag_force: assert property (@(posedge CLK) disable iff (RST)
      (SAMPLE_VALID && $signed(SAMPLE.magnitude) > $signed(s.mceil)
       && !SAMPLE.fault && !PROG_WE)
      |-> ##5 (OUT_VALID && OUT_VALUE == s.chi))
      else $error("magnitude error did not force high clamp");
   a_lock_hold: assert property (@(posedge CLK) disable iff (RST)
      (s.cust[`CW_LOCK] && PROG_WE) |=> $stable(s.cust) && $stable(s.sp))
      else $error("locked memory changed");
   a_band_high: assert property (@(posedge CLK) disable iff (RST)
      (s.vld[3] && s.dflt[3] && !s.cust[`CW_NOFORCE] && !s.cust[`CW_LOCK])
      |=> OUT_VALUE == `ERR_BAND_HIGH)
      else $error("unlocked fault did not use high band");
   a_short_tri: assert property (@(posedge CLK) disable iff (RST)
      (s.cust[`CW_SHORT] == 2'h3 && SHORT_LOW_SIDE)
      |=> OUT_DRIVE == angle_cond_pkg::DRV_TRI)
      else $error("low side short did not tristate");
   a_bit_time: assert property (@(posedge CLK) disable iff (RST)
      s.cust[`CW_SPEED] [*2] |-> BIT_TIME == 20'(BIT_FAST_CYC))
      else $error("bit time does not follow speed bit");
   a_diag_latch: assert property (@(posedge CLK) disable iff (RST)
      (s.cust[`CW_LATCH] && s.status[0]) |=> s.status[0])
      else $error("latched diagnosis bit dropped");
   a_comm_pin: assert property (@(posedge CLK) disable iff (RST)
      $rose(s.cust[`CW_COMM]) |=> PIN_COMMUNICATION_MODE)
      else $error("pin communication not enabled");

endmodule // angle_output_conditioning

// ==== testbench/pin_reader.sv ====
// Model of the controller that reads the conditioned output and
// supplies the setpoint values. Assumes one clock shared with the block.
`timescale 1ns/10ps

module pin_reader (
   input  wire logic        clk,
   input  wire logic        out_valid,
   input  wire logic [15:0] out_value,
   input  wire logic [5:0]  sp_index,
   output logic [15:0]      sp_value,
   output logic [15:0]      last_value
);
   // monotonic points, 1024 apart.
   // Point nine is bowed upward so interpolation is visible.
   always_comb
   begin
      sp_value = 16'(sp_index) * 16'h0400;
      if (sp_index == 6'h09)
         sp_value = sp_value + 16'h0200;
   end

   // The reader only trusts a value in the cycle it is announced.
   always_ff @(posedge clk)
   begin
      if (out_valid)
         last_value <= out_value;
   end
endmodule // pin_reader

// ==== testbench/test_angle_output_conditioning.sv ====
// Self-checking bench for the angle output conditioning block.
// Assumes the defs header, the package and the pin reader come first.
`timescale 1ns/10ps
`include "angle_cond_defs.svh"

module test_angle_output_conditioning;
   localparam int SLOW = 40, FAST = 10, P1K = 40, P500 = 80;
   localparam int P200 = 200, P2K = 20;
   logic                    CLK = 1'b0;
   logic                    RST = 1'b1;
   logic                    PROG_WE = 1'b0;
   logic [5:0]              PROG_SEL = 6'h00;
   logic [15:0]             PROG_WDATA = 16'h0000;
   logic                    SAMPLE_VALID = 1'b0;
   angle_cond_pkg::sample_s SAMPLE = '0;
   logic                    SHORT_HIGH_SIDE = 1'b0;
   logic                    SHORT_LOW_SIDE = 1'b0;
   logic [15:0]             PROG_RDATA, HELD_FIRST, HELD_SECOND, OUT_VALUE;
   logic                    OUT_VALID, PULSE_11BIT, DIGITAL_OUTPUT_FORMAT;
   logic                    PIN_COMMUNICATION_MODE, MEMORY_LOCKED;
   angle_cond_pkg::drive_e  OUT_DRIVE;
   logic [5:0]              DIAG_STATUS, sp_index = 6'h00;
   logic [19:0]             BIT_TIME, PULSE_PERIOD;
   logic [15:0]             sp_value, last_value, ov, rv;
   logic [15:0]             c1 = 16'h0000, c2 = 16'h0000;
   int                      errors = 0, samples_checked = 0;

   // Short count parameters keep the decoded periods easy to compare.
   angle_output_conditioning #(.BIT_SLOW_CYC(SLOW), .BIT_FAST_CYC(FAST),
      .PWM_1K_CYC(P1K), .PWM_500_CYC(P500), .PWM_200_CYC(P200),
      .PWM_2K_CYC(P2K)) DUT (.CLK(CLK), .RST(RST), .PROG_WE(PROG_WE),
      .PROG_SEL(PROG_SEL), .PROG_WDATA(PROG_WDATA),
      .PROG_RDATA(PROG_RDATA), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE(SAMPLE), .SHORT_HIGH_SIDE(SHORT_HIGH_SIDE),
      .SHORT_LOW_SIDE(SHORT_LOW_SIDE), .HELD_FIRST(HELD_FIRST),
      .HELD_SECOND(HELD_SECOND), .OUT_VALUE(OUT_VALUE),
      .OUT_VALID(OUT_VALID), .OUT_DRIVE(OUT_DRIVE),
      .DIAG_STATUS(DIAG_STATUS), .BIT_TIME(BIT_TIME),
      .PULSE_PERIOD(PULSE_PERIOD), .PULSE_11BIT(PULSE_11BIT),
      .DIGITAL_OUTPUT_FORMAT(DIGITAL_OUTPUT_FORMAT),
      .PIN_COMMUNICATION_MODE(PIN_COMMUNICATION_MODE),
      .MEMORY_LOCKED(MEMORY_LOCKED));

   pin_reader reader (.clk(CLK), .out_valid(OUT_VALID),
      .out_value(OUT_VALUE), .sp_index(sp_index), .sp_value(sp_value),
      .last_value(last_value));

   // Free running 125 MHz clock.
   initial
   begin
      forever #4 CLK = ~CLK;
   end

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [19:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic reset_dut(input int n);
      @(posedge CLK);
      RST <= 1'b1;
      repeat (n) @(posedge CLK);
      RST <= 1'b0;
   endtask

   // One write strobe per call; the strobe drops on the following edge.
   task automatic wr(input logic [5:0] s, input logic [15:0] d);
      @(posedge CLK);
      PROG_WE <= 1'b1;
      PROG_SEL <= s;
      PROG_WDATA <= d;
      @(posedge CLK);
      PROG_WE <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] s);
      @(posedge CLK);
      PROG_SEL <= s;
      repeat (2) @(posedge CLK);
      #1 rv = PROG_RDATA;
   endtask

   // Sends one sample and waits a bounded time for its result.
   task automatic smp(input logic [15:0] a, m, input logic f);
      int n;
      @(posedge CLK);
      SAMPLE_VALID <= 1'b1;
      SAMPLE <= '{ch1: c1, ch2: c2, angle: a, magnitude: m, fault: f};
      @(posedge CLK);
      SAMPLE_VALID <= 1'b0;
      for (n = 1; n <= 8; n++)
      begin
         @(posedge CLK);
         #1;
         if (OUT_VALID === 1'b1)
            break;
      end
      if (n > 8)
      begin
         errors++;
         $display("Error output valid never came");
         stop_test();
      end
      chk("latency", 20'(n), 4);
      @(posedge CLK);
      #1 ov = last_value;
   endtask

   task automatic step(input logic [5:0] s, input logic [15:0] d, a, m,
                       input logic [15:0] e, input logic [5:0] k);
      wr(s, d);
      smp(a, m, 1'b0);
      chk("output", ov, e);
      chk("status", DIAG_STATUS, k);
   endtask

   task automatic t_regs();
      logic [5:0]  s [8] = '{`IDX_SCALE, `IDX_CHI, `IDX_MFLOOR, `IDX_MCEIL,
                             `IDX_SP0, 6'h20, `IDX_SPN, 6'h3F};
      logic [15:0] e [8] = '{`RST_SCALE, `RST_CHI, `RST_MFLOOR, `RST_MCEIL,
                             16'h0000, 16'h4000, 16'h8000, 16'h0000};
      for (int i = 0; i < 8; i++)
      begin
         rd(s[i]);
         chk("reset value", rv, e[i]);
      end
      $display("Finished register reset values");
   endtask

   // Each row changes one setting and checks the arithmetic result.
   task automatic t_path();
      reset_dut(2);
      for (int i = 0; i < 33; i++)
      begin
         sp_index = 6'(i);
         #1 wr(6'(`IDX_SP0 + i), sp_value);
      end
      step(`IDX_SHIFT, 16'h0000, 16'h4000, 16'h0100, 16'h2000, 6'h00);
      step(`IDX_SHIFT, 16'h0800, 16'h4000, 16'h0100, 16'h3000, 6'h00);
      step(`IDX_SCALE, 16'h0400, 16'h4000, 16'h0100, 16'h5000, 6'h00);
      step(`IDX_REF, 16'h2000, 16'h4000, 16'h0100, 16'h3000, 6'h00);
      step(`IDX_PRE, 16'h1000, 16'h4000, 16'h0100, 16'h4000, 6'h00);
      step(`IDX_LP, 16'h0000, 16'h5200, 16'h0100, 16'h5300, 6'h00);
      step(`IDX_LP, 16'h0001, 16'h3000, 16'h0100, 16'h4180, 6'h00);
      step(`IDX_LP, 16'h0000, 16'h3000, 16'h0100, 16'h3000, 6'h00);
      step(`IDX_WRAP, 16'h0001, 16'h5400, 16'h0100, 16'h2000, 6'h00);
      step(`IDX_WRAP, 16'h0002, 16'h7000, 16'h0100, 16'h3000, 6'h00);
      step(`IDX_CLO, 16'h3800, 16'h7000, 16'h0100, 16'h3800, 6'h04);
      step(`IDX_WRAP, 16'h0000, 16'h7000, 16'h0100, 16'h7000, 6'h00);
      step(`IDX_CHI, 16'h6000, 16'h7000, 16'h0100, 16'h6000, 6'h08);
      step(`IDX_MFLOOR, 16'h0010, 16'h4000, 16'h0005, 16'h6000, 6'h01);
      step(`IDX_MCEIL, 16'h0100, 16'h4000, 16'h0200, 16'h6000, 6'h02);
      $display("Finished signal path");
   endtask

   // Decodes of the configuration word, including the unused top bit.
   task automatic t_word();
      logic [19:0] per [4] = '{P1K, P500, P200, P2K};
      logic [15:0] w;
      for (int k = 0; k < 4; k++)
      begin
         w = 16'h8000 | (16'(k) << 10) | (k[0] ? 16'h3010 : 16'h0000);
         wr(`IDX_CUST, w);
         rd(`IDX_CUST);
         chk("word readback", rv, w & `CW_MASK);
         chk("bit time", BIT_TIME, k[0] ? FAST : SLOW);
         chk("format", DIGITAL_OUTPUT_FORMAT, k[0]);
         chk("pulse period", PULSE_PERIOD, per[k]);
         chk("reduced res", PULSE_11BIT, k == 3);
         chk("pin comm", PIN_COMMUNICATION_MODE, k[0]);
      end
      $display("Finished configuration word");
   endtask

   task automatic t_short();
      angle_cond_pkg::drive_e lo [4] = '{angle_cond_pkg::DRV_NORMAL,
         angle_cond_pkg::DRV_HIGH, angle_cond_pkg::DRV_LOW,
         angle_cond_pkg::DRV_TRI};
      for (int m = 0; m < 4; m++)
         for (int j = 0; j < 2; j++)
         begin
            wr(`IDX_CUST, 16'(m) << 8);
            SHORT_LOW_SIDE <= (j == 0);
            SHORT_HIGH_SIDE <= (j == 1);
            repeat (3) @(posedge CLK);
            #1 chk("drive", OUT_DRIVE, (j == 1 && m == 3) ? 0 : lo[m]);
            @(posedge CLK);
            SHORT_LOW_SIDE <= 1'b0;
            SHORT_HIGH_SIDE <= 1'b0;
         end
      $display("Finished short handling");
   endtask

   // Unlocked parts always use the high band; bit one lifts forcing.
   task automatic t_fault();
      logic [15:0] w [4] = '{16'h0000, 16'h0080, 16'h0002, 16'h0081};
      logic [15:0] e [4] = '{16'hFFFF, 16'hFFFF, 16'h2000, 16'h0000};
      reset_dut(2);
      for (int i = 0; i < 4; i++)
      begin
         wr(`IDX_CUST, w[i]);
         smp(16'h4000, 16'h0100, 1'b1);
         chk("fault output", ov, e[i]);
      end
      chk("locked", MEMORY_LOCKED, 1'b1);
      wr(`IDX_SCALE, 16'h0400);
      rd(`IDX_SCALE);
      chk("locked write", rv, `RST_SCALE);
      $display("Finished fault and lock");
   endtask

   task automatic t_hyst();
      logic [15:0] h [4] = '{16'hFFFC, 16'hFFFC, 16'hFFFC, 16'h0000};
      logic [15:0] v [4] = '{16'h0064, 16'h0066, 16'h006E, 16'h006F};
      logic [15:0] e [4] = '{16'h0064, 16'h0064, 16'h006E, 16'h006F};
      reset_dut(2);
      for (int i = 0; i < 4; i++)
      begin
         wr(`IDX_HYST, h[i]);
         c1 = v[i];
         c2 = v[i];
         smp(16'h4000, 16'h0100, 1'b0);
         chk("held first", HELD_FIRST, e[i]);
         chk("held second", HELD_SECOND, e[i]);
      end
      $display("Finished hysteresis");
   endtask

   task automatic t_latch();
      for (int l = 0; l < 2; l++)
      begin
         reset_dut(2);
         wr(`IDX_CUST, l[0] ? 16'h0004 : 16'h0000);
         wr(`IDX_MFLOOR, 16'h0010);
         smp(16'h4000, 16'h0005, 1'b0);
         smp(16'h4000, 16'h0100, 1'b0);
         chk("field_magnitude_floor kept", DIAG_STATUS[0], l[0]);
      end
      $display("Finished diagnosis latch");
   endtask

   initial
   begin
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      t_regs();
      t_path();
      t_word();
      t_short();
      t_fault();
      t_hyst();
      t_latch();
      stop_test();
   end
endmodule // test_angle_output_conditioning
